//--- ssk_checker.sv
// Concurrent checks on the link between follower and processor end.
// Assumes one mclk domain and the instance made beside the link.
`timescale 1ns/1ns
`default_nettype none
module ssk_checker
    import ssk_pkg::*;
#(
    parameter int FRAMES = 256
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic write_clock_gate,
    input wire logic preset_load,
    input wire logic [SEC_W-1:0] preset_sector,
    input wire logic [CNT_W-1:0] skew_value,
    input wire logic sector_start_seen_flag,
    input wire logic [SEC_W-1:0] sector_number,
    input wire logic a_channel_strobe,
    input wire logic b_channel_strobe,
    input wire logic [7:0] timing_waves,
    input wire logic decoded_sector_pulse,
    input wire logic [CNT_W-1:0] intra_sector_count_out,
    input wire logic index_pulse_n,
    input wire logic sector_start_n
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // Bus request and its single wait state
    sequence req_rise;
        $rose(avs_read) || $rose(avs_write);
    endsequence
    sequence one_wait;
        avs_waitrequest ##1 !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    // Gate may lag through follower flops, so three quiet cycles
    sequence gate_quiet;
        write_clock_gate && $past(write_clock_gate) && $past(write_clock_gate, 2);
    endsequence

    a_bus_one_wait: assert property (req_rise |-> one_wait)
        else $error("waitrequest not low for one cycle");
    a_strobe_map: assert property (a_channel_strobe == timing_waves[0] && b_channel_strobe == timing_waves[1])
        else $error("strobes differ from table bits");
    a_strobe_excl: assert property (!(a_channel_strobe && b_channel_strobe))
        else $error("both sample strobes high");
    a_count_step: assert property ($changed(intra_sector_count_out) |-> intra_sector_count_out == 8'h0 || intra_sector_count_out == $past(intra_sector_count_out) + 8'h1)
        else $error("intra-sector count jumped");
    a_count_range: assert property (intra_sector_count_out < FRAMES)
        else $error("intra-sector count out of range");
    a_sync_zero: assert property (decoded_sector_pulse |-> intra_sector_count_out == 8'h0 ##1 !decoded_sector_pulse)
        else $error("sector pulse not aligned to count zero");
    a_index_wrap: assert property (!index_pulse_n |-> sector_number == 7'h0 && $past(sector_number) == 7'h5c ##1 index_pulse_n)
        else $error("index pulse not at sector wrap");
    a_preset_load: assert property (preset_load |-> ##[1:2] sector_number == ($past(preset_sector) < SECTORS ? $past(preset_sector) : 7'h0))
        else $error("preset sector not loaded");
    a_sos_compare: assert property ((!sector_start_n and gate_quiet) |-> intra_sector_count_out == $past(skew_value))
        else $error("start of sector without count match");
    a_gate_forces: assert property (!write_clock_gate [*3] |-> !sector_start_n)
        else $error("gate low did not force start of sector");
    a_flag_set: assert property (!sector_start_n |-> ##[0:2] sector_start_seen_flag)
        else $error("presence flag not set");
endmodule // ssk_checker
`default_nettype wire

//--- ssk_follower.sv
// Track follower digital timing: gate generator, sector decoder,
// intra-sector counter, once-around counter, skew measure and compare.
// Assumes the recovered loop clock, servo dibits, data clock pulse and
// the 4 MHz processor clock arrive as asynchronous pins.
`timescale 1ns/1ns
`default_nettype none
module ssk_follower
    import ssk_pkg::*;
#(
    parameter int FRAMES = SECTOR_FRAMES
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic loop_clock_in,
    input wire logic servo_dibit_in,
    input wire logic data_surface_clock_pulse,
    input wire logic processor_clock_4m,
    ssk_if.follower lnk,
    output logic a_channel_strobe,
    output logic b_channel_strobe,
    output logic [7:0] timing_waves,
    output logic decoded_sector_pulse,
    output logic [CNT_W-1:0] intra_sector_count_out,
    output logic index_pulse_n,
    output logic sector_start_n
);

    // Counter must fit the sector length and hold a usable skew range
    if (FRAMES > (1 << CNT_W) || FRAMES < 8)
    begin : g_bad_frames
        $error("FRAMES does not fit the intra-sector counter");
    end

    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FRAMES - 1);
    localparam int PIN_LOOP = 0;
    localparam int PIN_DIBIT = 1;
    localparam int PIN_DCP = 2;
    localparam int PIN_4M = 3;

    // Rising edge of a synchronised pin
    function automatic logic rise(input logic now, input logic was);
        rise = now & ~was;
    endfunction

    logic [3:0] pin_meta_q;
    logic [3:0] pin_sync_q;
    logic [3:0] pin_prev_q;
    logic [3:0] pin_meta_d;
    logic [3:0] pin_sync_d;
    logic [3:0] pin_prev_d;
    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] div_d;
    logic [7:0] wave_q;
    logic [7:0] wave_d;
    logic dibit_prev_q;
    logic dibit_prev_d;
    logic extra_q;
    logic extra_d;
    logic [3:0] hist_q;
    logic [3:0] hist_d;
    logic dec_q;
    logic dec_d;
    logic odd_q;
    logic odd_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [SEC_W-1:0] sec_q;
    logic [SEC_W-1:0] sec_d;
    logic idx_n_q;
    logic idx_n_d;
    logic [CNT_W-1:0] meas_q;
    logic [CNT_W-1:0] meas_d;
    logic sos_n_q;
    logic sos_n_d;
    logic seen_q;
    logic seen_d;

    // Decoded events of the current cycle
    logic loop_edge;
    logic frame_end;
    logic dibit_src;
    logic dibit_edge;
    logic [7:0] wave_now;
    logic [3:0] hist_next;
    logic sector_hit;
    logic sector_mark;
    logic skew_latch;
    logic sos_event;

    // Next-state logic for the whole follower
    always_comb
    begin
        // Two flops on every pin before any logic looks at it
        pin_meta_d = {processor_clock_4m, data_surface_clock_pulse, servo_dibit_in, loop_clock_in};
        pin_sync_d = pin_meta_q;
        pin_prev_d = pin_sync_q;

        // Divider advances on each rising edge of the recovered loop clock
        loop_edge = rise(pin_sync_q[PIN_LOOP], pin_prev_q[PIN_LOOP]);
        frame_end = loop_edge && (div_q == DIV_LAST);
        div_d = loop_edge ? div_q + 5'h01 : div_q;

        // Slot bits and track parity address the waveform table
        wave_now = WAVE_ROM[{lnk.track_lsb, div_q[DIV_W-1 -: SLOT_W]}];
        wave_d = wave_now;

        // Self test swaps servo read data for the processor clock
        dibit_src = lnk.selftest_enable ? pin_sync_q[PIN_4M] : pin_sync_q[PIN_DIBIT];
        dibit_prev_d = dibit_src;
        dibit_edge = rise(dibit_src, dibit_prev_q);

        // A dibit inside the extra window marks this frame
        extra_d = extra_q;
        if (frame_end)
        begin
            extra_d = 1'b0;
        end
        else if (dibit_edge && wave_now[WV_EXTRA_WIN])
        begin
            extra_d = 1'b1;
        end

        // Frame history matched against both sector patterns
        hist_next = {hist_q[2:0], extra_q};
        hist_d = frame_end ? hist_next : hist_q;
        sector_hit = frame_end && (hist_next == EVEN_PAT || hist_next == ODD_PAT);
        dec_d = sector_hit;
        odd_d = sector_hit ? (hist_next == ODD_PAT) : odd_q;

        // Sync only at a frame edge, so pulse and count stay in step
        cnt_d = cnt_q;
        if (sector_hit)
        begin
            cnt_d = '0;
        end
        else if (frame_end)
        begin
            cnt_d = (cnt_q == CNT_LAST) ? '0 : cnt_q + 1'b1;
        end
        sector_mark = frame_end && (cnt_d == '0);

        // Once-around count of sector marks, preset wins over counting
        sec_d = sec_q;
        idx_n_d = 1'b1;
        if (lnk.preset_load)
        begin
            sec_d = (lnk.preset_sector < SECTORS) ? lnk.preset_sector : '0;
        end
        else if (sector_mark)
        begin
            sec_d = (sec_q == SECTORS - 7'h01) ? '0 : sec_q + 7'h01;
            idx_n_d = (sec_q != SECTORS - 7'h01);
        end

        // Skew latch on data surface pulse, or on decoded start in self test
        skew_latch = rise(pin_sync_q[PIN_DCP], pin_prev_q[PIN_DCP])
                     || (lnk.selftest_enable && sector_hit);
        meas_d = skew_latch ? cnt_q : meas_q;

        // Start of sector on compare, or forced while the gate is low
        sos_event = (frame_end && (cnt_d == lnk.skew_value)) || !lnk.write_clock_gate;
        sos_n_d = !sos_event;

        // Presence flag: a new pulse beats a clear in the same cycle
        seen_d = seen_q;
        if (sos_event)
        begin
            seen_d = 1'b1;
        end
        else if (lnk.flag_clear)
        begin
            seen_d = 1'b0;
        end
    end

    // State registers, frozen while ce is low
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_meta_q <= 4'h0;
            pin_sync_q <= 4'h0;
            pin_prev_q <= 4'h0;
            div_q <= 5'h00;
            wave_q <= 8'h00;
            dibit_prev_q <= 1'b0;
            extra_q <= 1'b0;
            hist_q <= 4'h0;
            dec_q <= 1'b0;
            odd_q <= 1'b0;
            cnt_q <= '0;
            sec_q <= '0;
            idx_n_q <= 1'b1;
            meas_q <= '0;
            sos_n_q <= 1'b1;
            seen_q <= 1'b0;
        end
        else if (ce)
        begin
            pin_meta_q <= pin_meta_d;
            pin_sync_q <= pin_sync_d;
            pin_prev_q <= pin_prev_d;
            div_q <= div_d;
            wave_q <= wave_d;
            dibit_prev_q <= dibit_prev_d;
            extra_q <= extra_d;
            hist_q <= hist_d;
            dec_q <= dec_d;
            odd_q <= odd_d;
            cnt_q <= cnt_d;
            sec_q <= sec_d;
            idx_n_q <= idx_n_d;
            meas_q <= meas_d;
            sos_n_q <= sos_n_d;
            seen_q <= seen_d;
        end
    end

    // Every output is a flop; strobes lag the slot by one mclk
    assign a_channel_strobe = wave_q[WV_A_STROBE];
    assign b_channel_strobe = wave_q[WV_B_STROBE];
    assign timing_waves = wave_q;
    assign decoded_sector_pulse = dec_q;
    assign intra_sector_count_out = cnt_q;
    assign index_pulse_n = idx_n_q;
    assign sector_start_n = sos_n_q;
    assign lnk.sector_start_seen_flag = seen_q;
    assign lnk.odd_track_seen = odd_q;
    assign lnk.sector_number = sec_q;
    assign lnk.skew_measure = meas_q;

endmodule // ssk_follower
`default_nettype wire

//--- ssk_if.sv
// Link between the track follower and the drive processor end.
// Assumes both ends run on the same mclk; no crossing inside.
`timescale 1ns/1ns
`default_nettype none
interface ssk_if;
    import ssk_pkg::*;

    // Processor to follower
    logic track_lsb;
    logic selftest_enable;
    logic write_clock_gate;
    logic flag_clear;
    logic preset_load;
    logic [SEC_W-1:0] preset_sector;
    logic [CNT_W-1:0] skew_value;
    // Follower to processor
    logic sector_start_seen_flag;
    logic odd_track_seen;
    logic [SEC_W-1:0] sector_number;
    logic [CNT_W-1:0] skew_measure;

    modport follower (
        input track_lsb, selftest_enable, write_clock_gate, flag_clear,
        input preset_load, preset_sector, skew_value,
        output sector_start_seen_flag, odd_track_seen, sector_number, skew_measure
    );
    modport proc (
        output track_lsb, selftest_enable, write_clock_gate, flag_clear,
        output preset_load, preset_sector, skew_value,
        input sector_start_seen_flag, odd_track_seen, sector_number, skew_measure
    );
endinterface
`default_nettype wire

//--- ssk_pkg.sv
// Shared constants for the servo sector timing pair: the track follower
// end and the drive processor end.
// Assumes both ends are clocked by the same 20 MHz mclk.
package ssk_pkg;

    // Gate generator divider and slot decode
    localparam int DIV_W = 5;              // five-stage binary divider
    localparam int SLOT_W = 4;             // upper four divider bits
    localparam int SLOT_NS = 115;          // nominal slot length in ns
    localparam logic [4:0] DIV_LAST = 5'h1f;

    // Waveform table bit positions
    localparam int WV_A_STROBE = 0;
    localparam int WV_B_STROBE = 1;
    localparam int WV_EXTRA_WIN = 2;

    // 8 outputs by 32 entries; index is {track_lsb, slot}
    localparam logic [7:0] WAVE_ROM [32] = '{
        8'h18, 8'h28, 8'h21, 8'h21, 8'h10, 8'h10, 8'h44, 8'h44,
        8'h18, 8'h28, 8'h22, 8'h22, 8'h10, 8'h10, 8'h44, 8'h44,
        8'h18, 8'h28, 8'h22, 8'h22, 8'h10, 8'h10, 8'h44, 8'h44,
        8'h18, 8'h28, 8'h21, 8'h21, 8'h10, 8'h10, 8'h44, 8'h44
    };

    // Extra-dibit history patterns marking a sector start
    localparam logic [3:0] EVEN_PAT = 4'hb;
    localparam logic [3:0] ODD_PAT = 4'hd;

    // Intra-sector and once-around counting
    localparam int CNT_W = 8;
    localparam int SECTOR_FRAMES = 256;
    localparam int SEC_W = 7;
    localparam logic [6:0] SECTORS = 7'h5d;   // 93 marks per band

    // Processor register map (word index on the Avalon bus)
    localparam int ADDR_W = 3;
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_PRESET = 3'h1;
    localparam logic [2:0] REG_SKEW = 3'h2;
    localparam logic [2:0] REG_STATUS = 3'h3;
    localparam logic [2:0] REG_MEASURE = 3'h4;

    // Control register fields and reset value
    localparam int CTRL_LSB = 0;
    localparam int CTRL_SELFTEST = 1;
    localparam int CTRL_WCG = 2;
    localparam int CTRL_CLEAR = 3;
    localparam logic [2:0] CTRL_RESET = 3'h4;  // write clock gate passing

    // Status register fields
    localparam int STAT_SEEN = 0;
    localparam int STAT_ODD = 1;
    localparam int STAT_SEC_LO = 8;

endpackage

//--- ssk_proc.sv
// Drive processor end: Avalon-MM slave registers that steer the track
// follower and report its sector state.
// Assumes the Avalon master shares mclk and holds requests until
// waitrequest is low.
`timescale 1ns/1ns
`default_nettype none
module ssk_proc
    import ssk_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    ssk_if.proc lnk
);

    logic wait_q;
    logic wait_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [2:0] ctrl_q;
    logic [2:0] ctrl_d;
    logic clear_q;
    logic clear_d;
    logic load_q;
    logic load_d;
    logic [SEC_W-1:0] preset_q;
    logic [SEC_W-1:0] preset_d;
    logic [CNT_W-1:0] skew_q;
    logic [CNT_W-1:0] skew_d;
    logic take;
    logic wr_take;

    // One wait cycle, then the request is taken on the low edge
    always_comb
    begin
        take = (avs_read || avs_write) && !wait_q;
        wr_take = take && avs_write;
        wait_d = !((avs_read || avs_write) && wait_q);
        rdata_d = rdata_q;
        ctrl_d = ctrl_q;
        preset_d = preset_q;
        skew_d = skew_q;
        clear_d = wr_take && (avs_address == REG_CTRL) && avs_writedata[CTRL_CLEAR];
        load_d = wr_take && (avs_address == REG_PRESET);
        if (wr_take && avs_address == REG_CTRL)
        begin
            ctrl_d = avs_writedata[2:0];
        end
        if (load_d)
        begin
            preset_d = avs_writedata[SEC_W-1:0];
        end
        if (wr_take && avs_address == REG_SKEW)
        begin
            skew_d = avs_writedata[CNT_W-1:0];
        end
        // Read data prepared while waitrequest is still high
        if ((avs_read || avs_write) && wait_q)
        begin
            case (avs_address)
                REG_CTRL: rdata_d = {29'h0, ctrl_q};
                REG_PRESET: rdata_d = {25'h0, lnk.sector_number};
                REG_SKEW: rdata_d = {24'h0, skew_q};
                REG_STATUS: rdata_d = {17'h0, lnk.sector_number, 6'h0,
                                       lnk.odd_track_seen, lnk.sector_start_seen_flag};
                REG_MEASURE: rdata_d = {24'h0, lnk.skew_measure};
                default: rdata_d = 32'h0;
            endcase
        end
    end

    // Register stage, frozen while ce is low
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0;
            ctrl_q <= CTRL_RESET;
            clear_q <= 1'b0;
            load_q <= 1'b0;
            preset_q <= '0;
            skew_q <= '0;
        end
        else if (ce)
        begin
            wait_q <= wait_d;
            rdata_q <= rdata_d;
            ctrl_q <= ctrl_d;
            clear_q <= clear_d;
            load_q <= load_d;
            preset_q <= preset_d;
            skew_q <= skew_d;
        end
    end

    // Link outputs all from flops; offset averaging is firmware work
    assign avs_waitrequest = wait_q;
    assign avs_readdata = rdata_q;
    assign lnk.track_lsb = ctrl_q[CTRL_LSB];
    assign lnk.selftest_enable = ctrl_q[CTRL_SELFTEST];
    assign lnk.write_clock_gate = ctrl_q[CTRL_WCG];
    assign lnk.flag_clear = clear_q;
    assign lnk.preset_load = load_q;
    assign lnk.preset_sector = preset_q;
    assign lnk.skew_value = skew_q;

endmodule // ssk_proc
`default_nettype wire

//--- tb_servo_sector_timing.sv
// Self-checking bench: follower and processor end joined by the link.
// Assumes FRAMES shortened to 8 so sectors pass quickly.
`timescale 1ns/1ns
`default_nettype none
module tb_servo_sector_timing
    import ssk_pkg::*;
;
    localparam int FR = 8;
    localparam int LIMIT = 30000;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic loop_clock_in = 1'b0;
    logic servo_dibit_in = 1'b0;
    logic data_surface_clock_pulse = 1'b0;
    logic processor_clock_4m = 1'b0;
    logic [2:0] avs_address = 3'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic a_channel_strobe, b_channel_strobe, decoded_sector_pulse, index_pulse_n, sector_start_n;
    logic [7:0] timing_waves;
    logic [7:0] intra_sector_count_out;
    logic [3:0] ph = 4'h0;
    logic odd = 1'b0;
    logic [31:0] rd, v;
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0;
    int n, p, s0;

    ssk_if lnk();
    ssk_follower #(.FRAMES(FR)) i_ssk_follower (.mclk(mclk), .rst_n(rst_n), .ce(1'b1),
        .loop_clock_in(loop_clock_in), .servo_dibit_in(servo_dibit_in),
        .data_surface_clock_pulse(data_surface_clock_pulse), .processor_clock_4m(processor_clock_4m),
        .lnk(lnk.follower), .a_channel_strobe(a_channel_strobe), .b_channel_strobe(b_channel_strobe),
        .timing_waves(timing_waves), .decoded_sector_pulse(decoded_sector_pulse),
        .intra_sector_count_out(intra_sector_count_out), .index_pulse_n(index_pulse_n),
        .sector_start_n(sector_start_n));
    ssk_proc i_ssk_proc (.mclk(mclk), .rst_n(rst_n), .ce(1'b1), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .lnk(lnk.proc));
    ssk_checker #(.FRAMES(FR)) i_ssk_checker (.mclk(mclk), .rst_n(rst_n), .avs_read(avs_read),
        .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .write_clock_gate(lnk.write_clock_gate),
        .preset_load(lnk.preset_load), .preset_sector(lnk.preset_sector), .skew_value(lnk.skew_value),
        .sector_start_seen_flag(lnk.sector_start_seen_flag), .sector_number(lnk.sector_number),
        .a_channel_strobe(a_channel_strobe), .b_channel_strobe(b_channel_strobe),
        .timing_waves(timing_waves), .decoded_sector_pulse(decoded_sector_pulse),
        .intra_sector_count_out(intra_sector_count_out), .index_pulse_n(index_pulse_n),
        .sector_start_n(sector_start_n));

    always #25 mclk = ~mclk;

    // Extra dibits keyed to the count, so sync lands on the natural wrap
    function automatic logic pat_bit(input logic o, input logic [7:0] c);
        case (c)
            8'h4, 8'h7: return 1'b1;
            8'h5: return o;
            8'h6: return !o;
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic [6:0] next_sec(input logic [6:0] s);
        return (s == 7'h5c) ? 7'h0 : s + 7'h1;
    endfunction

    // Loop clock, 4 MHz stand-in, servo dibits and the hang guard
    always @(posedge mclk)
    begin
        ph <= ph + 4'h1;
        loop_clock_in <= ph[1];
        processor_clock_4m <= ph[2];
        servo_dibit_in <= timing_waves[WV_EXTRA_WIN] & pat_bit(odd, intra_sector_count_out);
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            n_mismatch = n_mismatch + 1;
            conclude();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count = check_count + 1;
        if (g !== e)
        begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One Avalon access; held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] wd);
        @(posedge mclk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= wd;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rd_chk(input string nm, input logic [2:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask

    task automatic wait_pulse();
        do @(negedge mclk); while (decoded_sector_pulse !== 1'b1);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        void'($urandom(53));
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        rd_chk("ctrl", REG_CTRL, 32'h4);
        rd_chk("skew", REG_SKEW, 32'h0);
        rd_chk("measure", REG_MEASURE, 32'h0);
        rd_chk("unmapped", 3'h5, 32'h0);
        // Random values with noise in the upper bits
        for (int i = 0; i < 4; i++)
        begin
            v = $urandom;
            bus(1'b1, REG_SKEW, v);
            rd_chk("skew", REG_SKEW, {24'h0, v[7:0]});
            bus(1'b1, REG_CTRL, {v[31:4], 1'b0, 1'b1, v[1:0]});
            rd_chk("ctrl", REG_CTRL, {29'h0, 1'b1, v[1:0]});
        end
        // Even then odd pattern: pulses, sector advance, parity
        for (int o = 0; o < 2; o++)
        begin
            odd = o[0];
            bus(1'b1, REG_CTRL, {29'h0, 1'b1, 1'b0, odd});
            repeat (2) wait_pulse();
            chk("count at pulse", 32'h0, {24'h0, intra_sector_count_out});
            bus(1'b0, REG_STATUS, 32'h0);
            s0 = rd[14:8];
            wait_pulse();
            bus(1'b0, REG_STATUS, 32'h0);
            chk("status", {17'h0, next_sec(s0[6:0]), 6'h0, odd, 1'b0}, rd & 32'h7f02);
        end
        // Compare at a random skew, flag cleared then set again
        v = 1 + $urandom % 7;
        bus(1'b1, REG_SKEW, v);
        wait_pulse();
        bus(1'b1, REG_CTRL, {28'h0, 4'hc | {3'h0, odd}});
        bus(1'b0, REG_STATUS, 32'h0);
        chk("flag cleared", 32'h0, {31'h0, rd[0]});
        do @(negedge mclk); while (sector_start_n !== 1'b0);
        chk("count at start", v, {24'h0, intra_sector_count_out});
        bus(1'b0, REG_STATUS, 32'h0);
        chk("flag set", 32'h1, {31'h0, rd[0]});
        // Gate low forces start; flag held over a control write that sets bit 7, not the clear bit
        bus(1'b1, REG_CTRL, {31'h0, odd});
        repeat (4) @(negedge mclk);
        chk("forced start", 32'h0, {31'h0, sector_start_n});
        bus(1'b1, REG_CTRL, {28'h8, 3'h0, odd});
        bus(1'b0, REG_STATUS, 32'h0);
        chk("flag held", 32'h1, {31'h0, rd[0]});
        bus(1'b1, REG_CTRL, {29'h1, 2'h0, odd});
        // Data clock pulse latches the running count
        v = $urandom % 8;
        // Start from a fresh sector so the count cannot step mid-latch
        wait_pulse();
        do @(negedge mclk); while (intra_sector_count_out !== v[7:0]);
        @(posedge mclk);
        data_surface_clock_pulse <= 1'b1;
        repeat (4) @(posedge mclk);
        data_surface_clock_pulse <= 1'b0;
        rd_chk("measure", REG_MEASURE, {24'h0, v[7:0]});
        // Preset: out of range loads zero, then count to index
        wait_pulse();
        bus(1'b1, REG_PRESET, 32'h64);
        rd_chk("preset high", REG_PRESET, 32'h0);
        p = 88 + $urandom % 5;
        bus(1'b1, REG_PRESET, p);
        rd_chk("preset", REG_PRESET, p);
        n = 0;
        do
        begin
            @(negedge mclk);
            n = n + (decoded_sector_pulse === 1'b1);
        end
        while (index_pulse_n !== 1'b0);
        chk("sectors to index", 93 - p, n);
        // Self test: clock-fed dibits fill every frame, so no pattern match
        bus(1'b1, REG_CTRL, {28'h0, 4'h6 | {3'h0, odd}});
        repeat (640) @(negedge mclk);
        n = 0;
        repeat (1280)
        begin
            @(negedge mclk);
            n = n + (decoded_sector_pulse === 1'b1);
        end
        chk("selftest pulses", 0, n);
        conclude();
    end
endmodule // tb_servo_sector_timing
`default_nettype wire
